// file: baud_pkg.sv
// Purpose: shared constants and types for the baud-rate generator block
// Assumes: 8-bit register access port, one peripheral clock
// Notes: offsets are special-function addresses in the mapped area
package baud_pkg;
    localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'hc8;
    localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'hc9;
    localparam logic [7:0] BAUD_CONTROL_ADDR = 8'hca;
    localparam logic [7:0] BAUD_RELOAD_ADDR = 8'hcb;
    localparam logic [7:0] FRAC_DIV_CONTROL_ADDR = 8'hcc;
    localparam logic [7:0] FRAC_DIV_INCREMENT_ADDR = 8'hcd;
    localparam logic [7:0] FRAC_DIV_ACCUMULATOR_ADDR = 8'hce;
    localparam logic [7:0] REG_RESET = 8'h00;
    // baud_control fields
    localparam int RUN_BIT = 0;
    localparam int PRESCALE_LSB = 1;
    localparam int PRESCALE_W = 3;
    localparam logic [7:0] BAUD_CONTROL_MASK = 8'h0f;
    // frac_div_control fields
    localparam int FD_ENABLE_BIT = 0;
    localparam int FD_MODE_BIT = 1;
    localparam int FD_OVF_BIT = 2;
    localparam logic [7:0] FRAC_DIV_CONTROL_MASK = 8'h07;
    // serial control bits written by the channel
    localparam int SC_RX_FLAG_BIT = 0;
    localparam int SC_TX_FLAG_BIT = 1;
    localparam int SC_RX_BIT8_BIT = 2;
    // register access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic map_select;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage : baud_pkg

// file: frac_divider.sv
// Purpose: fractional divider, step/256 rate scaling by accumulator overflow
// Assumes: input clock event is a one-cycle enable pulse
// Notes: in normal divider mode it acts as a reload divider on the step value
`timescale 1ns/10ps
`default_nettype none
module frac_divider #(
    parameter int W = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic mode_sel_i,
    input wire logic tick_i,
    input wire logic [W-1:0] step_i,
    output logic tick_o,
    output logic [W-1:0] acc_o
);
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;
    logic tick_r;
    logic [W:0] sum;
    logic all_ones;
    logic fire;

    // fractional: add step, overflow gives one pulse; normal: count up to all ones
    assign sum = {1'b0, acc_r} + {1'b0, step_i};
    assign all_ones = &acc_r;
    assign fire = enable_i && tick_i && (mode_sel_i ? all_ones : sum[W]);
    assign acc_nxt = !enable_i ? acc_r :
                     !tick_i ? acc_r :
                     mode_sel_i ? (all_ones ? step_i : acc_r + 1'b1) :
                     sum[W-1:0];

    // accumulator and output pulse
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= '0;
            tick_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            tick_r <= fire;
        end
    end

    assign tick_o = tick_r;
    assign acc_o = acc_r;
endmodule : frac_divider
`default_nettype wire

// file: baud_gen.sv
// Purpose: baud-rate generator with its special-function registers
// Assumes: 8-bit register port sampled on sys_clk_i; reads answer combinationally
// Notes: baud_tick_o is the 16x oversampling clock pulse for the serial channel
`timescale 1ns/10ps
`default_nettype none
module baud_gen #(
    parameter int PRESCALE_CNT_W = 7
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire baud_pkg::reg_req_s req_i,
    input wire logic rx_flag_set_i,
    input wire logic tx_flag_set_i,
    input wire logic rx_bit8_i,
    input wire logic rx_data_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic [7:0] rdata_o,
    output logic baud_tick_o,
    output logic [7:0] serial_control_o,
    output logic [7:0] tx_data_o,
    output logic tx_load_o,
    output logic baud_running_o
);
    import baud_pkg::*;

    logic rst_sync1_r;
    logic rst_sync2_r;
    logic rst_n;
    logic [7:0] serial_control_r;
    logic [7:0] serial_buffer_r;
    logic [7:0] baud_control_r;
    logic [7:0] reload_r;
    logic [7:0] frac_ctrl_r;
    logic [7:0] step_r;
    logic [7:0] timer_r;
    logic [7:0] timer_nxt;
    logic [PRESCALE_CNT_W-1:0] pre_cnt_r;
    logic [PRESCALE_CNT_W-1:0] pre_mask;
    logic tx_load_r;
    logic baud_tick_r;
    logic mapped;
    logic wr_en;
    logic wr_sc;
    logic wr_sb;
    logic wr_bc;
    logic wr_rl;
    logic wr_fc;
    logic wr_fs;
    logic [PRESCALE_W-1:0] prescale_sel;
    logic run_bit;
    logic frac_div_enable;
    logic frac_div_mode_sel;
    logic prescaler_out_clock;
    logic frac_div_out_clock;
    logic timer_clk;
    logic timer_run;
    logic underflow;
    logic divider_overflow_set;
    logic [7:0] frac_acc;
    logic [7:0] sc_nxt;

    // reset release through two flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end else begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end
    assign rst_n = rst_sync2_r;

    // address decode, only inside the mapped area
    assign mapped = req_i.map_select;
    assign wr_en = req_i.wr && mapped;
    assign wr_sc = wr_en && (req_i.addr == SERIAL_CONTROL_ADDR);
    assign wr_sb = wr_en && (req_i.addr == SERIAL_BUFFER_ADDR);
    assign wr_bc = wr_en && (req_i.addr == BAUD_CONTROL_ADDR);
    assign wr_rl = wr_en && (req_i.addr == BAUD_RELOAD_ADDR);
    assign wr_fc = wr_en && (req_i.addr == FRAC_DIV_CONTROL_ADDR);
    assign wr_fs = wr_en && (req_i.addr == FRAC_DIV_INCREMENT_ADDR);

    // field extraction
    assign prescale_sel = baud_control_r[PRESCALE_LSB +: PRESCALE_W];
    assign run_bit = baud_control_r[RUN_BIT];
    assign frac_div_enable = frac_ctrl_r[FD_ENABLE_BIT];
    assign frac_div_mode_sel = frac_ctrl_r[FD_MODE_BIT];

    // prescaler: one pulse every 2^prescale_sel clocks
    assign pre_mask = PRESCALE_CNT_W'((1 << prescale_sel) - 1);
    assign prescaler_out_clock = ((pre_cnt_r & pre_mask) == '0);

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 1'b1;
        end
    end

    // fractional divider stage fed by the prescaler
    frac_divider #(
        .W(8)
    ) u_frac (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .enable_i(frac_div_enable),
        .mode_sel_i(frac_div_mode_sel),
        .tick_i(prescaler_out_clock),
        .step_i(step_r),
        .tick_o(frac_div_out_clock),
        .acc_o(frac_acc)
    );

    // timer clock source and run gating
    assign timer_clk = frac_div_enable ? frac_div_out_clock : prescaler_out_clock;
    assign timer_run = run_bit && !(frac_div_enable && frac_div_mode_sel);
    assign underflow = timer_run && timer_clk && (timer_r == 8'h00);
    // divide by reload+1 per tick, so rate follows the documented formula
    assign timer_nxt = !timer_run ? reload_r :
                       !timer_clk ? timer_r :
                       (timer_r == 8'h00) ? reload_r : timer_r - 1'b1;

    // baud timer and tick to the serial channel
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            timer_r <= REG_RESET;
            baud_tick_r <= 1'b0;
        end else begin
            timer_r <= timer_nxt;
            baud_tick_r <= underflow;
        end
    end

    // overflow flag: set in normal divider mode on each divider output
    assign divider_overflow_set = frac_div_enable && frac_div_mode_sel && frac_div_out_clock;

    // serial control: channel flags set, software write, set wins
    always_comb begin
        sc_nxt = wr_sc ? req_i.wdata : serial_control_r;
        if (rx_flag_set_i) begin
            sc_nxt[SC_RX_FLAG_BIT] = 1'b1;
            sc_nxt[SC_RX_BIT8_BIT] = rx_bit8_i;
        end
        if (tx_flag_set_i) begin
            sc_nxt[SC_TX_FLAG_BIT] = 1'b1;
        end
    end

    // generator and channel registers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_control_r <= REG_RESET;
            serial_buffer_r <= REG_RESET;
            baud_control_r <= REG_RESET;
            reload_r <= REG_RESET;
            frac_ctrl_r <= REG_RESET;
            step_r <= REG_RESET;
            tx_load_r <= 1'b0;
        end else begin
            serial_control_r <= sc_nxt;
            tx_load_r <= wr_sb;
            if (rx_data_valid_i) begin
                serial_buffer_r <= rx_data_i;
            end else if (wr_sb) begin
                serial_buffer_r <= req_i.wdata;
            end
            if (wr_bc) begin
                baud_control_r <= req_i.wdata & BAUD_CONTROL_MASK;
            end
            if (wr_rl) begin
                reload_r <= req_i.wdata;
            end
            if (divider_overflow_set) begin
                frac_ctrl_r[FD_OVF_BIT] <= 1'b1; // set beats clear
                if (wr_fc) begin
                    frac_ctrl_r[FD_MODE_BIT:FD_ENABLE_BIT] <= req_i.wdata[FD_MODE_BIT:0];
                end
            end else if (wr_fc) begin
                frac_ctrl_r <= req_i.wdata & FRAC_DIV_CONTROL_MASK;
            end
            if (wr_fs) begin
                step_r <= req_i.wdata;
            end
        end
    end

    // read mux, mapped area only, unmapped reads zero
    assign rdata_o = !(req_i.rd && mapped) ? 8'h00 :
        (req_i.addr == SERIAL_CONTROL_ADDR) ? serial_control_r :
        (req_i.addr == SERIAL_BUFFER_ADDR) ? serial_buffer_r :
        (req_i.addr == BAUD_CONTROL_ADDR) ? baud_control_r :
        (req_i.addr == BAUD_RELOAD_ADDR) ? timer_r :
        (req_i.addr == FRAC_DIV_CONTROL_ADDR) ? frac_ctrl_r :
        (req_i.addr == FRAC_DIV_INCREMENT_ADDR) ? step_r :
        (req_i.addr == FRAC_DIV_ACCUMULATOR_ADDR) ? frac_acc : 8'h00;

    assign baud_tick_o = baud_tick_r;
    assign serial_control_o = serial_control_r;
    assign tx_data_o = serial_buffer_r;
    assign tx_load_o = tx_load_r;
    assign baud_running_o = timer_run;
endmodule : baud_gen
`default_nettype wire

// file: baud_gen_properties.sv
// Purpose: port properties of the baud generator
// Assumes: one clock, reset active low
// Notes: bound to baud_gen from the bench top file
`timescale 1ns/10ps
`default_nettype none
module baud_gen_properties (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire baud_pkg::reg_req_s req_i,
    input wire logic rx_flag_set_i,
    input wire logic rx_bit8_i,
    input wire logic rx_data_valid_i,
    input wire logic [7:0] rdata_o,
    input wire logic baud_tick_o,
    input wire logic [7:0] serial_control_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_load_o,
    input wire logic baud_running_o
);
    import baud_pkg::*;
    // mapped read and buffer write decodes
    wire logic rd_m = req_i.rd && req_i.map_select;
    wire logic buf_wr = req_i.wr && req_i.map_select && req_i.addr == SERIAL_BUFFER_ADDR;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    tick_single_a: assert property (baud_tick_o |=> !baud_tick_o)
        else $error("baud tick longer than one cycle");
    stopped_no_tick_a: assert property (!baud_running_o ##1 !baud_running_o |-> !baud_tick_o)
        else $error("tick while timer stopped");
    unmapped_read_a: assert property (!req_i.map_select |-> rdata_o == 8'h00)
        else $error("read outside mapped area");
    idle_read_a: assert property (!req_i.rd |-> rdata_o == 8'h00)
        else $error("read data without read");
    baud_mask_a: assert property (rd_m && req_i.addr == BAUD_CONTROL_ADDR |-> rdata_o[7:4] == 4'h0)
        else $error("baud control upper bits set");
    frac_mask_a: assert property (rd_m && req_i.addr == FRAC_DIV_CONTROL_ADDR |-> rdata_o[7:3] == 5'h00)
        else $error("divider control upper bits set");
    buf_load_a: assert property (buf_wr && !rx_data_valid_i |=> tx_load_o && tx_data_o == $past(req_i.wdata))
        else $error("buffer write not loaded");
    load_cause_a: assert property (tx_load_o |-> $past(buf_wr))
        else $error("load pulse without write");
    rx_flag_a: assert property (rx_flag_set_i && !req_i.wr |=> serial_control_o[0] && serial_control_o[2] == $past(rx_bit8_i))
        else $error("receive flag not set");
endmodule : baud_gen_properties
`default_nettype wire

// file: serial_channel_model.sv
// Purpose: serial channel stand-in that consumes baud ticks
// Assumes: ten-bit frames at sixteen ticks a bit
// Notes: data lines toggle outside the frame-end pulse
`timescale 1ns/10ps
`default_nettype none
module serial_channel_model (
    input wire logic sys_clk_i,
    input wire logic baud_tick_i,
    output logic flags_o,
    output logic rx_bit8_o,
    output logic [7:0] rx_data_o,
    output logic [7:0] frames_o
);
    logic [7:0] ticks_r = 8'h00;
    initial {flags_o, rx_bit8_o, rx_data_o, frames_o} = '0;
    // count one frame of ticks, then report a byte received and one sent
    always @(negedge sys_clk_i) begin
        flags_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
        rx_bit8_o <= ~rx_bit8_o;
        if (baud_tick_i === 1'b1) begin
            ticks_r <= (ticks_r == 8'h9f) ? 8'h00 : ticks_r + 8'h01;
            if (ticks_r == 8'h9f) begin
                flags_o <= 1'b1;
                rx_data_o <= 8'ha5 ^ frames_o;
                rx_bit8_o <= frames_o[0];
                frames_o <= frames_o + 8'h01;
            end
        end
    end
endmodule : serial_channel_model
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the baud generator
// Assumes: 100 ns clock, inputs driven on the falling edge
// Notes: reads and tick spacing are checked against queued notes
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import baud_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    reg_req_s req = '0;
    logic [31:0] lf = 32'h7cc281cd;
    logic [7:0] rdata, rxd, frames, r, f0;
    logic tick, flags, rb8;
    logic [15:0] gap = 16'h0000;
    logic [7:0] rd_q[$];
    logic [15:0] gap_q[$];
    int bad_count = 0;
    int checks_done = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    baud_gen i_baud_gen (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .rx_flag_set_i(flags), .tx_flag_set_i(flags), .rx_bit8_i(rb8),
        .rx_data_valid_i(flags), .rx_data_i(rxd), .rdata_o(rdata), .baud_tick_o(tick),
        .serial_control_o(), .tx_data_o(), .tx_load_o(), .baud_running_o());
    serial_channel_model i_serial_channel_model (.sys_clk_i(sys_clk_i), .baud_tick_i(tick),
        .flags_o(flags), .rx_bit8_o(rb8), .rx_data_o(rxd), .frames_o(frames));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        // a tick spacing note left unanswered means a tick never came
        if (gap_q.size() > 0 || rd_q.size() > 0) bad_count++;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic bus(input logic r, input logic m, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        req = '{rd: r, wr: !r, map_select: m, addr: a, wdata: d};
        @(negedge sys_clk_i);
        req = '0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic m = 1'b1);
        bus(1'b0, m, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic m = 1'b1);
        rd_q.push_back(e);
        bus(1'b1, m, a, 8'h00);
    endtask : rd
    task automatic wait_tick();
        @(negedge sys_clk_i);
        for (int n = 0; n < 2000 && tick !== 1'b1; n++) @(negedge sys_clk_i);
    endtask : wait_tick
    task automatic gaps(input logic [15:0] g);
        wait_tick();
        wait_tick();
        @(posedge sys_clk_i);
        gap_q.push_back(g);
        gap_q.push_back(g);
        wait_tick();
        wait_tick();
    endtask : gaps
    // compare each read, and each tick spacing while a note is queued, against the oldest note
    always @(posedge sys_clk_i)
        if (req.rd === 1'b1) check("read", {8'h00, rd_q.pop_front()}, {8'h00, rdata});
    always @(negedge sys_clk_i) begin
        gap = gap + 16'h0001;
        if (tick === 1'b1) begin
            if (gap_q.size() > 0) check("gap", gap_q.pop_front(), gap);
            gap = 16'h0000;
        end
    end
    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        for (logic [8:0] a = 9'h0c8; a < 9'h0d0; a++) rd(a[7:0], 8'h00);
        wr(FRAC_DIV_ACCUMULATOR_ADDR, 8'h5a);
        rd(FRAC_DIV_ACCUMULATOR_ADDR, 8'h00);
        lf = lfsr(lf);
        wr(SERIAL_BUFFER_ADDR, lf[7:0]);
        wr(SERIAL_BUFFER_ADDR, ~lf[7:0], 1'b0);
        rd(SERIAL_BUFFER_ADDR, 8'h00, 1'b0);
        rd(SERIAL_BUFFER_ADDR, lf[7:0]);
        wr(BAUD_CONTROL_ADDR, 8'hf0);
        rd(BAUD_CONTROL_ADDR, 8'h00);
        wr(FRAC_DIV_CONTROL_ADDR, 8'hf8);
        rd(FRAC_DIV_CONTROL_ADDR, 8'h00);
        // normal divider mode holds the timer despite the run bit
        wr(FRAC_DIV_INCREMENT_ADDR, 8'h40);
        wr(FRAC_DIV_CONTROL_ADDR, 8'h03);
        wr(BAUD_RELOAD_ADDR, 8'h03);
        wr(BAUD_CONTROL_ADDR, 8'h01);
        repeat (50) @(posedge sys_clk_i);
        rd(BAUD_RELOAD_ADDR, 8'h03);
        // fractional mode, a quarter step on a reload of three
        wr(FRAC_DIV_CONTROL_ADDR, 8'h01);
        gaps(16'h0010);
        // prescaler path over three selects with random reloads
        wr(FRAC_DIV_CONTROL_ADDR, 8'h00);
        for (int p = 0; p < 3; p++) begin
            lf = lfsr(lf);
            r = {5'h00, lf[2:0] | 3'h1};
            wr(BAUD_RELOAD_ADDR, r);
            wr(BAUD_CONTROL_ADDR, {4'h0, p[2:0], 1'b1});
            gaps((16'h0001 << p) * (r + 16'h0001));
        end
        // a finished frame sets both flags and loads the received byte
        f0 = frames;
        for (int n = 0; n < 8000 && frames === f0; n++) @(posedge sys_clk_i);
        rd(SERIAL_CONTROL_ADDR, {5'h00, f0[0], 2'b11});
        rd(SERIAL_BUFFER_ADDR, 8'ha5 ^ f0);
        wr(BAUD_CONTROL_ADDR, 8'h00);
        rd(BAUD_RELOAD_ADDR, r);
        rst_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        rd(BAUD_RELOAD_ADDR, 8'h00);
        print_verdict();
    end
    // watchdog against a hung wait
    initial begin
        #3000000;
        bad_count++;
        print_verdict();
    end
endmodule : tb_top
bind baud_gen baud_gen_properties i_baud_gen_properties (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .req_i(req_i), .rx_flag_set_i(rx_flag_set_i), .rx_bit8_i(rx_bit8_i),
    .rx_data_valid_i(rx_data_valid_i), .rdata_o(rdata_o), .baud_tick_o(baud_tick_o),
    .serial_control_o(serial_control_o), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
    .baud_running_o(baud_running_o));
`default_nettype wire
